//--- adcs_master_model.sv
// bus master model: drives scl, pulls sda low, 200 ns bit time
// assumes the bench resolves sda with a pull-up
`timescale 1ns/10ps
`default_nettype none
module adcs_master_model (
    input wire logic mclk,
    input wire logic sdaBus,
    output var logic sclOut,
    output var logic sdaLow
);
    // idle bus, scl owned by the master only
    initial begin
        sclOut = 1'b1;
        sdaLow = 1'b0;
    end
    task automatic start_cond;
        @(posedge mclk) sdaLow <= 1'b1;
        repeat (4) @(posedge mclk);
        sclOut <= 1'b0;
    endtask : start_cond
    task automatic rep_start;
        @(posedge mclk) sdaLow <= 1'b0;
        repeat (4) @(posedge mclk);
        sclOut <= 1'b1;
        repeat (4) @(posedge mclk);
        start_cond();
    endtask : rep_start
    task automatic stop_cond;
        @(posedge mclk) sdaLow <= 1'b1;
        repeat (4) @(posedge mclk);
        sclOut <= 1'b1;
        repeat (4) @(posedge mclk);
        sdaLow <= 1'b0;
        repeat (8) @(posedge mclk);
    endtask : stop_cond
    // sda set in low phase, held over the high phase
    task automatic clk_bit(input logic b, output logic r);
        @(posedge mclk) sdaLow <= !b;
        repeat (4) @(posedge mclk);
        sclOut <= 1'b1;
        repeat (3) @(posedge mclk);
        r = sdaBus;
        sclOut <= 1'b0;
    endtask : clk_bit
    // eight bits then the acknowledge clock
    task automatic xfer_byte(input logic [7:0] d, input logic ackIn, output logic [7:0] q,
        output logic ackOut);
        logic b;
        for (int i = 7; i >= 0; i--) begin
            clk_bit(d[i], b);
            q[i] = b;
        end
        clk_bit(ackIn, ackOut);
    endtask : xfer_byte
endmodule : adcs_master_model
`default_nettype wire

//--- adcs_pkg.sv
// adcs_pkg: constants for the two-wire converter readout slave
// assumes a 40 MHz system clock; no other files depend on tool settings
package adcs_pkg;
    // ==========================================================
    // address byte layout
    localparam logic [3:0] DEV_CODE = 4'h6; // arbitrary value, fixed device code
    localparam logic [2:0] ADDR_OPT_RST = 3'h5; // default select option 101
    localparam int RW_BIT = 0;
    // ==========================================================
    // timing, in nanoseconds, at the 25 ns system clock
    localparam int CLK_PERIOD_NS = 25;
    localparam int ACQ_TIME_NS = 1120;
    localparam int CONV_TIME_NS = 8960;
    localparam int ACQ_CYCLES = (ACQ_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CONV_CYCLES = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TIMER_W = 10;
    // ==========================================================
    // result layout
    localparam int RESULT_W = 12;
    localparam logic [3:0] HI_PAD = 4'h0;
    // ==========================================================
    // states
    typedef enum logic [2:0] {
        ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_TX, ST_RX_ACK, ST_DONE
    } adcs_bus_state_t;
    typedef enum logic [1:0] {
        CV_IDLE, CV_ACQ, CV_CONV
    } adcs_conv_state_t;
endpackage : adcs_pkg

//--- adcs_readout.sv
// adcs_readout: two-wire slave front end of a 12-bit sampling converter
// assumes raw bus pins from outside the clock domain and an analog core that
// presents its finished code on sarCode when told to hold and convert
//
// Summary of operation
// - sda falling while scl high is a start; every command follows one.
// - sda rising while scl high is a stop; every operation ends with one.
// - data must be steady while scl high; changes there are start or stop.
// - one scl pulse per bit; the sender changes sda only while scl low.
// - acknowledging side holds sda low for the whole acknowledge high phase.
// - on a master not-acknowledge the device releases sda.
// - first byte is address; respond only on matching code and select bits.
// - read direction bit 1 selects a read and runs a conversion.
// - write direction is acknowledged, then the bus is released, no conversion.
// - no writable registers; write payload is not accepted.
// - sampling starts at the scl fall ending a high direction bit.
// - device drives acknowledge low for the address acknowledge clock.
// - first data byte is four zeros then the upper four result bits.
// - after master acknowledge the lower eight result bits follow.
// - repeat sampling starts at the scl fall of the result's last bit.
// - result goes most significant bit first, straight binary.
// - each finished conversion is kept in a 12-bit holding register.
// - acquisition 1.12 us and conversion 8.96 us, timed internally.
`timescale 1ns/10ps
`default_nettype none
module adcs_readout
    import adcs_pkg::*;
#(
    parameter int ACQ_CNT = ACQ_CYCLES,
    parameter int CONV_CNT = CONV_CYCLES
) (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic sclIn,
    input wire logic sdaIn,
    output logic sdaOut,
    output logic sdaOe,
    input wire logic addr_select_hi,
    input wire logic addr_select_mid,
    input wire logic addr_select_lo,
    input wire logic [adcs_pkg::RESULT_W-1:0] sarCode,
    output logic sampleHold,
    output logic convBusy,
    output logic [adcs_pkg::RESULT_W-1:0] resultHold
);
    import adcs_pkg::*;

    // refuse timing counts the sequencer timer cannot hold
    if (ACQ_CNT < 1 || CONV_CNT < 1 || ACQ_CNT >= (1 << TIMER_W) ||
        CONV_CNT >= (1 << TIMER_W)) begin : g_badTiming
        $error("adcs_readout: timing counts out of range");
    end

    // ==========================================================
    // input synchronisers
    logic [2:0] sclSync_reg, sclSync_next;
    logic [2:0] sdaSync_reg, sdaSync_next;
    logic sclLvl_reg, sclLvl_next, sdaLvl_reg, sdaLvl_next;
    logic [2:0] addrSel_reg;
    logic sclRise, sclFall, startSeen, stopSeen;

    // three stages; a change counts once stages two and three agree
    always_comb begin
        sclSync_next = {sclSync_reg[1:0], sclIn};
        sdaSync_next = {sdaSync_reg[1:0], sdaIn};
        sclLvl_next = sclLvl_reg;
        sdaLvl_next = sdaLvl_reg;
        if (sclSync_reg[1] == sclSync_reg[2]) begin
            sclLvl_next = sclSync_reg[2];
        end
        if (sdaSync_reg[1] == sdaSync_reg[2]) begin
            sdaLvl_next = sdaSync_reg[2];
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            sclSync_reg <= 3'h7;
            sdaSync_reg <= 3'h7;
            sclLvl_reg <= 1'b1;
            sdaLvl_reg <= 1'b1;
        end else begin
            sclSync_reg <= sclSync_next;
            sdaSync_reg <= sdaSync_next;
            sclLvl_reg <= sclLvl_next;
            sdaLvl_reg <= sdaLvl_next;
        end
        addrSel_reg <= {addr_select_hi, addr_select_mid, addr_select_lo};
    end

    // edge and condition detection on filtered levels
    assign sclRise = sclLvl_next & ~sclLvl_reg;
    assign sclFall = ~sclLvl_next & sclLvl_reg;
    assign startSeen = sclLvl_reg & sclLvl_next & sdaLvl_reg & ~sdaLvl_next;
    assign stopSeen = sclLvl_reg & sclLvl_next & ~sdaLvl_reg & sdaLvl_next;

    // ==========================================================
    // bus protocol engine
    adcs_bus_state_t busSt_reg, busSt_next;
    logic [3:0] bitCnt_reg, bitCnt_next;
    logic [7:0] shift_reg, shift_next;
    logic isRead_reg, isRead_next;
    logic lowByte_reg, lowByte_next;
    logic sdaOut_next, sdaOe_next;
    logic startConv;

    // conditions override data handling whenever scl is high
    always_comb begin
        busSt_next = busSt_reg;
        bitCnt_next = bitCnt_reg;
        shift_next = shift_reg;
        isRead_next = isRead_reg;
        lowByte_next = lowByte_reg;
        sdaOe_next = sdaOe;
        startConv = 1'b0;
        if (stopSeen) begin
            busSt_next = ST_IDLE;
            sdaOe_next = 1'b0;
        end else if (startSeen) begin
            busSt_next = ST_ADDR;
            bitCnt_next = 4'h0;
            sdaOe_next = 1'b0;
        end else begin
            case (busSt_reg)
                ST_IDLE, ST_DONE: begin
                    sdaOe_next = 1'b0;
                end
                ST_ADDR: begin
                    if (sclRise) begin
                        shift_next = {shift_reg[6:0], sdaLvl_next};
                        bitCnt_next = bitCnt_reg + 4'h1;
                    end
                    if (sclFall && bitCnt_reg == 4'h8) begin
                        if (shift_reg[7:4] == DEV_CODE && shift_reg[3:1] == addrSel_reg) begin
                            busSt_next = ST_ADDR_ACK;
                            isRead_next = shift_reg[RW_BIT];
                            // sample on fall ending read bit
                            startConv = shift_reg[RW_BIT];
                            sdaOe_next = 1'b1;
                        end else begin
                            busSt_next = ST_DONE;
                        end
                    end
                end
                // hold low through the acknowledge high phase
                ST_ADDR_ACK: begin
                    if (sclFall) begin
                        bitCnt_next = 4'h0;
                        lowByte_next = 1'b0;
                        if (isRead_reg) begin
                            busSt_next = ST_TX;
                            shift_next = {HI_PAD, resultHold[11:8]};
                            sdaOe_next = ~HI_PAD[3];
                        end else begin
                            busSt_next = ST_DONE;
                            sdaOe_next = 1'b0;
                        end
                    end
                end
                ST_TX: begin
                    if (sclFall) begin
                        bitCnt_next = bitCnt_reg + 4'h1;
                        if (bitCnt_reg == 4'h7) begin
                            busSt_next = ST_RX_ACK;
                            sdaOe_next = 1'b0;
                            // next sample at fall of last result bit
                            startConv = lowByte_reg;
                        end else begin
                            shift_next = {shift_reg[6:0], 1'b0};
                            sdaOe_next = ~shift_reg[6];
                        end
                    end
                end
                ST_RX_ACK: begin
                    if (sclRise) begin
                        if (sdaLvl_next) begin
                            busSt_next = ST_DONE;
                        end else begin
                            lowByte_next = ~lowByte_reg;
                            // next byte chosen on master acknowledge
                            shift_next = lowByte_reg ? {HI_PAD, resultHold[11:8]}
                                                     : resultHold[7:0];
                        end
                    end
                    // first bit of the next byte goes out as the acknowledge ends
                    if (sclFall) begin
                        busSt_next = ST_TX;
                        bitCnt_next = 4'h0;
                        sdaOe_next = ~shift_reg[7];
                    end
                end
                default: begin
                    busSt_next = ST_IDLE;
                    sdaOe_next = 1'b0;
                end
            endcase
        end
        sdaOut_next = 1'b0;
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            busSt_reg <= ST_IDLE;
            bitCnt_reg <= 4'h0;
            shift_reg <= 8'h00;
            isRead_reg <= 1'b0;
            lowByte_reg <= 1'b0;
            sdaOut <= 1'b0;
            sdaOe <= 1'b0;
        end else begin
            busSt_reg <= busSt_next;
            bitCnt_reg <= bitCnt_next;
            shift_reg <= shift_next;
            isRead_reg <= isRead_next;
            lowByte_reg <= lowByte_next;
            sdaOut <= sdaOut_next;
            sdaOe <= sdaOe_next;
        end
    end

    // ==========================================================
    // self-timed acquisition and conversion sequencer
    adcs_conv_state_t cvSt_reg, cvSt_next;
    logic [TIMER_W-1:0] timer_reg, timer_next;
    logic [RESULT_W-1:0] result_next;
    logic sampleHold_next, convBusy_next;

    // fixed internal timing, independent of scl
    always_comb begin
        cvSt_next = cvSt_reg;
        timer_next = timer_reg;
        result_next = resultHold;
        case (cvSt_reg)
            CV_ACQ: begin
                if (timer_reg == '0) begin
                    cvSt_next = CV_CONV;
                    timer_next = TIMER_W'(CONV_CNT - 1);
                end else begin
                    timer_next = timer_reg - 1'b1;
                end
            end
            CV_CONV: begin
                if (timer_reg == '0) begin
                    cvSt_next = CV_IDLE;
                    result_next = sarCode;
                end else begin
                    timer_next = timer_reg - 1'b1;
                end
            end
            default: begin
                cvSt_next = CV_IDLE;
            end
        endcase
        // a request starts a sample or restarts a running one; idle holds in default
        if (startConv) begin
            cvSt_next = CV_ACQ;
            timer_next = TIMER_W'(ACQ_CNT - 1);
        end
        sampleHold_next = (cvSt_next == CV_ACQ);
        convBusy_next = (cvSt_next != CV_IDLE);
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            cvSt_reg <= CV_IDLE;
            timer_reg <= '0;
            resultHold <= '0;
            sampleHold <= 1'b0;
            convBusy <= 1'b0;
        end else begin
            cvSt_reg <= cvSt_next;
            timer_reg <= timer_next;
            resultHold <= result_next;
            sampleHold <= sampleHold_next;
            convBusy <= convBusy_next;
        end
    end
endmodule : adcs_readout
`default_nettype wire

//--- adcs_readout_monitor.sv
// checker for adcs_readout: sda timing and conversion outputs
// assumes the scl low phase lasts at least five mclk cycles
`timescale 1ns/10ps
`default_nettype none
module adcs_readout_monitor #(
    parameter int ACQ_CNT = 4,
    parameter int CONV_CNT = 8
) (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic sclIn,
    input wire logic sdaOut,
    input wire logic sdaOe,
    input wire logic [adcs_pkg::RESULT_W-1:0] sarCode,
    input wire logic sampleHold,
    input wire logic convBusy,
    input wire logic [adcs_pkg::RESULT_W-1:0] resultHold
);
    import adcs_pkg::*;
    logic sclPrev_reg;
    logic [3:0] fallAge_reg;
    logic [7:0] acqCnt_reg;
    logic [8:0] busyCnt_reg;
    // ========================================
    // age of last scl fall, hold and busy lengths
    always_ff @(posedge mclk) begin
        sclPrev_reg <= sclIn;
        fallAge_reg <= sys_rst ? 4'hf : (sclPrev_reg && !sclIn) ? 4'h1
            : fallAge_reg + 4'(fallAge_reg != 4'hf);
        acqCnt_reg <= sampleHold ? acqCnt_reg + 8'h01 : 8'h00;
        busyCnt_reg <= convBusy ? busyCnt_reg + 9'h001 : 9'h000;
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);
    sequence s_convStart; $rose(convBusy); endsequence
    sequence s_convEnd; $fell(convBusy); endsequence
    property p_openDrain; sdaOut == 1'b0; endproperty
    property p_oeInLow; $changed(sdaOe) |-> !sclIn && fallAge_reg inside {[4'h1:4'h6]}; endproperty
    property p_holdInBusy; sampleHold |-> convBusy; endproperty
    property p_startAfterFall; s_convStart |-> fallAge_reg inside {[4'h1:4'h7]}; endproperty
    property p_acqFirst; s_convStart |-> sampleHold ##1 sampleHold [*2]; endproperty
    property p_acqLen;
        $fell(sampleHold) |-> convBusy && acqCnt_reg inside {[ACQ_CNT-1:ACQ_CNT+1]};
    endproperty
    property p_busyLen;
        s_convEnd |-> busyCnt_reg inside {[ACQ_CNT+CONV_CNT-1:ACQ_CNT+CONV_CNT+1]};
    endproperty
    property p_resultLoad; s_convEnd |-> ##[0:2] resultHold == sarCode; endproperty
    property p_resultAtEnd;
        $changed(resultHold) |-> !convBusy && ($past(convBusy) || $past(convBusy, 2));
    endproperty
    a_openDrain: assert property (p_openDrain) else $error("sda driven high");
    a_oeInLow: assert property (p_oeInLow) else $error("sda moved off scl low");
    a_holdInBusy: assert property (p_holdInBusy) else $error("hold outside busy");
    a_startAfterFall: assert property (p_startAfterFall) else $error("late start");
    a_acqFirst: assert property (p_acqFirst) else $error("no acquisition");
    a_acqLen: assert property (p_acqLen) else $error("acquisition length");
    a_busyLen: assert property (p_busyLen) else $error("conversion length");
    a_resultLoad: assert property (p_resultLoad) else $error("result not kept");
    a_resultAtEnd: assert property (p_resultAtEnd) else $error("result moved");
endmodule : adcs_readout_monitor
bind adcs_readout adcs_readout_monitor #(.ACQ_CNT(ACQ_CNT), .CONV_CNT(CONV_CNT)) u_mon (
    .mclk(mclk), .sys_rst(sys_rst), .sclIn(sclIn), .sdaOut(sdaOut), .sdaOe(sdaOe),
    .sarCode(sarCode), .sampleHold(sampleHold), .convBusy(convBusy), .resultHold(resultHold));
`default_nettype wire

//--- adcs_readout_tb_top.sv
// testbench for adcs_readout driven by the bus master model
// assumes package, design, checker and master model compiled first
`timescale 1ns/10ps
`default_nettype none
module adcs_readout_tb_top;
    import adcs_pkg::*;
    logic mclk, sys_rst, sclIn, sdaLow, sdaOut, sdaOe, sampleHold, convBusy;
    logic [2:0] optSel;
    logic [RESULT_W-1:0] sarCode, resultHold, prevCode;
    int error_cnt, n_tests, convCnt;
    // open-drain sda with pull-up
    wire logic sdaBus = (sdaOe ? sdaOut : 1'b1) && !sdaLow;
    // 40 MHz clock
    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = !mclk;
    end
    // count conversions started
    always @(posedge convBusy) convCnt++;
    adcs_readout #(.ACQ_CNT(4), .CONV_CNT(100)) DUT (
        .mclk(mclk), .sys_rst(sys_rst), .sclIn(sclIn), .sdaIn(sdaBus), .sdaOut(sdaOut),
        .sdaOe(sdaOe), .addr_select_hi(optSel[2]), .addr_select_mid(optSel[1]),
        .addr_select_lo(optSel[0]), .sarCode(sarCode), .sampleHold(sampleHold),
        .convBusy(convBusy), .resultHold(resultHold));
    adcs_master_model MST (.mclk(mclk), .sdaBus(sdaBus), .sclOut(sclIn), .sdaLow(sdaLow));
    task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : check
    task automatic tally_and_finish;
        $display("checks %0d errors %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : tally_and_finish
    // foreign code or select bits get no answer
    task automatic t_nomatch;
        logic [7:0] q;
        logic ack;
        int c0;
        c0 = convCnt;
        for (int k = 0; k < 2; k++) begin
            MST.start_cond();
            MST.xfer_byte(k ? {DEV_CODE ^ 4'h8, optSel, 1'b1} : {DEV_CODE, optSel ^ 3'h1, 1'b1},
                1'b1, q, ack);
            check(16'(ack), 16'h0001, "foreign address ack");
            MST.stop_cond();
        end
        check(16'(convCnt - c0), 16'h0000, "foreign conversion");
    endtask : t_nomatch
    // read of pairs, master ack asks for more
    task automatic t_read(input int pairs, input logic [11:0] code, input logic rep);
        logic [7:0] hi, lo;
        logic ack;
        int c0;
        c0 = convCnt;
        @(posedge mclk) sarCode <= code;
        if (rep) MST.rep_start();
        else MST.start_cond();
        MST.xfer_byte({DEV_CODE, optSel, 1'b1}, 1'b1, hi, ack);
        check(16'(ack), 16'h0000, "address ack");
        for (int p = 0; p < pairs; p++) begin
            MST.xfer_byte(8'hff, 1'b0, hi, ack);
            MST.xfer_byte(8'hff, p == pairs - 1, lo, ack);
            check({hi, lo}, {HI_PAD, prevCode}, "result bytes");
            prevCode = code;
        end
        repeat (4) @(posedge mclk);
        check(16'(sdaOe), 16'h0000, "release after nak");
        MST.stop_cond();
        for (int i = 0; i < 400 && convBusy !== 1'b0; i++) @(posedge mclk);
        check(16'(convBusy), 16'h0000, "conversion timeout");
        check(16'(convCnt - c0 >= pairs), 16'h0001, "conversion count");
        check(16'(resultHold), 16'(code), "held result");
        if (convBusy !== 1'b0) tally_and_finish();
    endtask : t_read
    // write direction: ack, payload refused, then repeated start read
    task automatic t_poll;
        logic [7:0] q;
        logic ack;
        int c0;
        c0 = convCnt;
        MST.start_cond();
        MST.xfer_byte({DEV_CODE, optSel, 1'b0}, 1'b1, q, ack);
        check(16'(ack), 16'h0000, "poll ack");
        MST.xfer_byte(8'h5a, 1'b1, q, ack);
        check(16'(ack), 16'h0001, "payload ack");
        check(16'(convCnt - c0), 16'h0000, "poll conversion");
        t_read(1, 12'h000, 1'b1);
    endtask : t_poll
    // main sequence
    initial begin
        sys_rst = 1'b1;
        optSel = ADDR_OPT_RST;
        sarCode = 12'h000;
        prevCode = 12'h000;
        error_cnt = 0;
        n_tests = 0;
        convCnt = 0;
        repeat (5) @(posedge mclk);
        sys_rst <= 1'b0;
        repeat (8) @(posedge mclk);
        t_nomatch();
        t_read(1, 12'ha5c, 1'b0);
        t_read(3, 12'h3f1, 1'b0);
        @(posedge mclk) optSel <= 3'h2;
        t_nomatch();
        t_read(1, 12'hfff, 1'b0);
        t_poll();
        tally_and_finish();
    end
endmodule : adcs_readout_tb_top
`default_nettype wire
